// file: shared/pmc_regs.svh
// Register offsets, field positions, reset values and key constants of the power mode controller.
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
`define PMC_MODE_OFFSET   32'h4000_2400
`define PMC_KEY_OFFSET    32'h4000_2404
`define PMC_CTRL_OFFSET   32'h4000_2480
`define PMC_STAT_OFFSET   32'h4000_2484
`define PMC_MODE_LSB      0
`define PMC_MODE_MSB      1
`define PMC_MODE_RESET    16'h0000
`define PMC_KEY_RESET     16'h0000
`define PMC_KEY_FIRST     16'h4859
`define PMC_KEY_SECOND    16'hF27B
`define PMC_SCR_DEEP_A    4'h4
`define PMC_SCR_DEEP_B    4'h6
`endif

// file: shared/pmc_pkg.sv
// Types shared by both ends of the power mode controller.
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_ACTIVE    = 2'h0,
    PMC_CORE_NAP  = 2'h1,
    PMC_SYS_NAP   = 2'h2,
    PMC_HIBERNATE = 2'h3
  } pmc_mode_e;
  typedef enum logic [2:0] {
    PMC_KS_LOCKED = 3'h1,
    PMC_KS_HALF   = 3'h2,
    PMC_KS_OPEN   = 3'h4
  } pmc_key_e;
endpackage : pmc_pkg

// file: shared/pmc_if.sv
// Interface between the processor side and the power mode controller.
`timescale 1ns/10ps
interface pmc_if;
  logic [31:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        sleeping;
  logic        deep_sleep;
  logic        in_handler;
  logic        wake;
  logic        wake_hi_prio;
  logic        debug_hold;
  modport ctrl (input addr, wdata, wr, rd, sleeping, deep_sleep, in_handler, wake,
                wake_hi_prio, debug_hold, output rdata);
  modport core (output addr, wdata, wr, rd, sleeping, deep_sleep, in_handler, wake,
                wake_hi_prio, debug_hold, input rdata);
endinterface : pmc_if

// file: hw/pmc_ctrl.sv
// Power mode controller: key-protected mode register and clock and power gating.
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`include "pmc_regs.svh"
module pmc_ctrl
  import pmc_pkg::*;
(
  // Clock and resets.
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic por_reset,
  // Link to the processor side.
  pmc_if.ctrl       bus,
  // Gating and power outputs.
  output logic      core_clk_en,
  output logic      bus_clk_en,
  output logic      irq_clk_en,
  output logic      logic_pwr_en,
  output logic      retain,
  output logic      asleep
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  pmc_mode_e mode_q;
  pmc_key_e  key_q;
  logic [15:0] key_val_q;
  logic debug_hold_q;
  logic handler_sleep_q;
  logic sleep_q;
  logic wake_ok;
  logic wr_mode;
  logic wr_key;

  assign wr_mode = bus.wr && (bus.addr == `PMC_MODE_OFFSET);
  assign wr_key  = bus.wr && (bus.addr == `PMC_KEY_OFFSET);
  // A sleep entered inside a handler only ends on a higher priority wake.
  assign wake_ok = handler_sleep_q ? bus.wake_hi_prio : bus.wake;

  // ----------------------------------------------------------------
  // Key sequencer
  // ----------------------------------------------------------------
  // Tracks the two-write unlock; any stray write relocks.
  always_ff @(posedge clock) begin
    if (reset) begin
      key_q     <= PMC_KS_LOCKED;
      key_val_q <= `PMC_KEY_RESET;
    end else if (wr_key) begin
      key_val_q <= bus.wdata;
      if (bus.wdata == `PMC_KEY_FIRST) begin
        key_q <= PMC_KS_HALF;
      end else if (bus.wdata == `PMC_KEY_SECOND && key_q == PMC_KS_HALF) begin
        key_q <= PMC_KS_OPEN;
      end else begin
        key_q <= PMC_KS_LOCKED;
      end
    end else if (wr_mode) begin
      key_q <= PMC_KS_LOCKED;
    end else if (bus.wr) begin
      key_q <= PMC_KS_LOCKED;
    end
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // Holds the last accepted mode; a wake that ends a sleep returns it to active.
  always_ff @(posedge clock) begin
    if (reset) begin
      mode_q <= PMC_ACTIVE;
    end else if (sleep_q && wake_ok) begin
      mode_q <= PMC_ACTIVE;
    end else if (wr_mode && key_q == PMC_KS_OPEN) begin
      mode_q <= pmc_mode_e'(bus.wdata[`PMC_MODE_MSB:`PMC_MODE_LSB]);
    end
  end

  // ----------------------------------------------------------------
  // Sleep tracking
  // ----------------------------------------------------------------
  // Low power gating takes hold once the core reports sleep in a non-active mode, with deep sleep for hibernate, unless debug hold is set.
  always_ff @(posedge clock) begin
    if (reset) begin
      sleep_q         <= 1'b0;
      handler_sleep_q <= 1'b0;
    end else if (sleep_q) begin
      if (wake_ok) begin
        sleep_q         <= 1'b0;
        handler_sleep_q <= 1'b0;
      end
    end else if (bus.sleeping && mode_q != PMC_ACTIVE && !debug_hold_q) begin
      if (mode_q != PMC_HIBERNATE || bus.deep_sleep) begin
        sleep_q         <= 1'b1;
        handler_sleep_q <= bus.in_handler;
      end
    end
  end

  // Debug hold survives ordinary resets; only power-on clears it.
  always_ff @(posedge clock) begin
    if (por_reset) begin
      debug_hold_q <= 1'b0;
    end else if (bus.debug_hold) begin
      debug_hold_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Gating outputs
  // ----------------------------------------------------------------
  // In active mode core sleep is left to the core itself.
  always_ff @(posedge clock) begin
    if (reset) begin
      core_clk_en  <= 1'b1;
      bus_clk_en   <= 1'b1;
      irq_clk_en   <= 1'b1;
      logic_pwr_en <= 1'b1;
      retain       <= 1'b0;
      asleep       <= 1'b0;
    end else begin
      core_clk_en  <= !(sleep_q && !wake_ok);
      bus_clk_en   <= !(sleep_q && !wake_ok && mode_q >= PMC_SYS_NAP);
      irq_clk_en   <= !(sleep_q && !wake_ok && mode_q == PMC_HIBERNATE);
      logic_pwr_en <= !(sleep_q && !wake_ok && mode_q == PMC_HIBERNATE);
      retain       <= sleep_q && !wake_ok && mode_q == PMC_HIBERNATE;
      asleep       <= sleep_q && !wake_ok;
    end
  end

  // Read data one cycle after the strobe; reserved bits read zero.
  always_ff @(posedge clock) begin
    if (reset) begin
      bus.rdata <= 16'h0000;
    end else if (bus.rd) begin
      case (bus.addr)
        `PMC_MODE_OFFSET: bus.rdata <= {14'h0000, mode_q};
        `PMC_KEY_OFFSET:  bus.rdata <= key_val_q;
        `PMC_STAT_OFFSET: bus.rdata <= {12'h000, debug_hold_q, handler_sleep_q,
                                        sleep_q, key_q == PMC_KS_OPEN};
        default:          bus.rdata <= 16'h0000;
      endcase
    end else begin
      bus.rdata <= 16'h0000;
    end
  end

endmodule : pmc_ctrl

// file: hw/pmc_core.sv
// Processor-side end: turns user requests into bus accesses and sleep signalling.
`timescale 1ns/10ps
`include "pmc_regs.svh"
module pmc_core
  import pmc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  // User request side.
  input  wire logic [31:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic        req_wr,
  input  wire logic        req_rd,
  input  wire logic        req_sleep,
  input  wire logic        req_deep,
  input  wire logic        req_handler,
  input  wire logic        req_wake,
  input  wire logic        req_wake_hi,
  input  wire logic        req_debug,
  output logic      [15:0] rsp_rdata,
  // Link to the controller.
  pmc_if.core              bus
);

  // Registers every request onto the link, dropping a write that comes with a read; sleep level persists until a wake.
  always_ff @(posedge clock) begin
    if (reset) begin
      bus.addr         <= 32'h0000_0000;
      bus.wdata        <= 16'h0000;
      bus.wr           <= 1'b0;
      bus.rd           <= 1'b0;
      bus.sleeping     <= 1'b0;
      bus.deep_sleep   <= 1'b0;
      bus.in_handler   <= 1'b0;
      bus.wake         <= 1'b0;
      bus.wake_hi_prio <= 1'b0;
      bus.debug_hold   <= 1'b0;
      rsp_rdata        <= 16'h0000;
    end else begin
      bus.addr         <= req_addr;
      bus.wdata        <= req_wdata;
      bus.wr           <= req_wr && !req_rd;
      bus.rd           <= req_rd;
      // While the handler flag is set, a sleep ends only on a higher priority wake.
      bus.sleeping     <= req_sleep ||
                          (bus.sleeping && !(bus.in_handler ? req_wake_hi : req_wake));
      bus.deep_sleep   <= req_deep;
      bus.in_handler   <= req_handler;
      bus.wake         <= req_wake;
      bus.wake_hi_prio <= req_wake_hi;
      bus.debug_hold   <= req_debug;
      rsp_rdata        <= bus.rdata;
    end
  end

endmodule : pmc_core

// file: dv/pmc_ctrl_assertions.sv
// Checker on the link and gating outputs of the power mode controller.
`timescale 1ns/10ps
module pmc_ctrl_assertions (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        reset,
  // Link signals.
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        sleeping,
  input wire logic        in_handler,
  input wire logic        wake,
  input wire logic        wake_hi_prio,
  // Gating outputs.
  input wire logic        core_clk_en,
  input wire logic        bus_clk_en,
  input wire logic        irq_clk_en,
  input wire logic        logic_pwr_en,
  input wire logic        retain
);
  // ------
  // Checks
  // ------
  // All checks use the one clock and rest during reset.
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // High when every clock and supply is on.
  wire all_on = core_clk_en && bus_clk_en && irq_clk_en && logic_pwr_en && !retain;
  property p_rd_idle; !rd |=> rdata == 16'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_rst_on; $fell(reset) |-> all_on; endproperty
  a_rst_on: assert property (p_rst_on) else $error("gating after reset");
  property p_irq; !retain |-> irq_clk_en; endproperty
  a_irq: assert property (p_irq) else $error("irq clock stopped in nap");
  property p_hib; retain |-> !logic_pwr_en && !irq_clk_en; endproperty
  a_hib: assert property (p_hib) else $error("hibernate left power on");
  property p_idle; (!in_handler && !sleeping) [*2] |-> all_on; endproperty
  a_idle: assert property (p_idle) else $error("gated while awake");
  property p_wake; $rose(wake) && !in_handler |=> all_on; endproperty
  a_wake: assert property (p_wake) else $error("wake left gating");
  property p_hi; $rose(wake_hi_prio) |=> all_on; endproperty
  a_hi: assert property (p_hi) else $error("priority wake left gating");
  property p_hold; !core_clk_en && in_handler && !wake_hi_prio |=> !core_clk_en; endproperty
  a_hold: assert property (p_hold) else $error("handler sleep left early");
  // Main scenarios reached.
  c_hib: cover property (retain);
  c_nap: cover property (!core_clk_en && bus_clk_en);
  c_hand: cover property (in_handler && !core_clk_en);
endmodule : pmc_ctrl_assertions

// file: dv/testbench.sv
// Testbench joining both ends of the power mode controller.
`timescale 1ns/10ps
`include "pmc_regs.svh"
module testbench import pmc_pkg::*; ;
  // -------
  // Signals
  // -------
  localparam logic [31:0] mode_a = `PMC_MODE_OFFSET;
  localparam logic [31:0] key_a = `PMC_KEY_OFFSET;
  logic        clock = 1'h0;
  logic        reset = 1'h1;
  logic        por_reset = 1'h1;
  logic [31:0] req_addr = 32'h0;
  logic [15:0] req_wdata = 16'h0;
  logic        req_wr = 1'h0, req_rd = 1'h0, req_sleep = 1'h0, req_deep = 1'h0;
  logic        req_handler = 1'h0, req_wake = 1'h0, req_wake_hi = 1'h0, req_debug = 1'h0;
  logic [15:0] rsp_rdata;
  logic        core_clk_en, bus_clk_en, irq_clk_en, logic_pwr_en, retain, asleep;
  int          num_errors = 0;
  int          checked = 0;
  // Rows: mode, then expected core, bus, irq, power enables and retention.
  logic [6:0]  rows [4] = '{{2'h0, 5'h1E}, {2'h1, 5'h0E}, {2'h2, 5'h06}, {2'h3, 5'h01}};
  // Clock at 200 MHz.
  always #2.5 clock = ~clock;
  pmc_if bus_if ();
  pmc_core u_pmc_core (.clock, .reset, .req_addr, .req_wdata, .req_wr, .req_rd, .req_sleep,
    .req_deep, .req_handler, .req_wake, .req_wake_hi, .req_debug, .rsp_rdata, .bus(bus_if));
  pmc_ctrl u_pmc_ctrl (.clock, .reset, .por_reset, .bus(bus_if), .core_clk_en, .bus_clk_en,
    .irq_clk_en, .logic_pwr_en, .retain, .asleep);
  pmc_ctrl_assertions u_pmc_ctrl_assertions (.clock, .reset, .rd(bus_if.rd),
    .rdata(bus_if.rdata), .sleeping(bus_if.sleeping), .in_handler(bus_if.in_handler),
    .wake(bus_if.wake), .wake_hi_prio(bus_if.wake_hi_prio), .core_clk_en, .bus_clk_en,
    .irq_clk_en, .logic_pwr_en, .retain);
  // -----
  // Tasks
  // -----
  // Counts a comparison and reports a mismatch.
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clock);
    req_addr <= a;
    req_wdata <= d;
    req_wr <= 1'h1;
    @(posedge clock);
    req_wr <= 1'h0;
  endtask : wr
  // Read data come back three edges after the strobe leaves the bench.
  task rdc(input logic [31:0] a, input logic [15:0] e, input string n);
    @(posedge clock);
    req_addr <= a;
    req_rd <= 1'h1;
    @(posedge clock);
    req_rd <= 1'h0;
    repeat (2) @(posedge clock);
    #1 chk(n, e, rsp_rdata);
  endtask : rdc
  task setm(input logic [1:0] m);
    wr(key_a, `PMC_KEY_FIRST);
    wr(key_a, `PMC_KEY_SECOND);
    wr(mode_a, {14'h0, m});
  endtask : setm
  task gc(input logic [4:0] e);
    repeat (4) @(posedge clock);
    #1 chk("gates", {11'h0, e}, {11'h0, core_clk_en, bus_clk_en, irq_clk_en, logic_pwr_en, retain});
    chk("asleep", {15'h0, ~e[4]}, {15'h0, asleep});
  endtask : gc
  task sl(input logic [4:0] e);
    @(posedge clock);
    req_sleep <= 1'h1;
    @(posedge clock);
    req_sleep <= 1'h0;
    gc(e);
  endtask : sl
  task wk(input logic hi, input logic [4:0] e);
    @(posedge clock);
    if (hi) req_wake_hi <= 1'h1;
    else req_wake <= 1'h1;
    @(posedge clock);
    req_wake <= 1'h0;
    req_wake_hi <= 1'h0;
    gc(e);
  endtask : wk
  task rst(input logic por);
    reset <= 1'h1;
    por_reset <= por;
    repeat (4) @(posedge clock);
    reset <= 1'h0;
    por_reset <= 1'h0;
  endtask : rst
  task finish_test();
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // --------
  // Sequence
  // --------
  // Reset values first, then table rows, relock, handler sleep and debug hold.
  initial begin
    rst(1'h1);
    rdc(mode_a, `PMC_MODE_RESET, "mode");
    rdc(key_a, `PMC_KEY_RESET, "key");
    foreach (rows[i]) begin
      req_deep <= rows[i][6:5] == 2'h3;
      setm(rows[i][6:5]);
      rdc(mode_a, {14'h0, rows[i][6:5]}, "mode");
      sl(rows[i][4:0]);
      wk(1'h0, 5'h1E);
      rdc(mode_a, 16'h0, "mode");
    end
    req_deep <= 1'h0;
    wr(mode_a, 16'h1);
    rdc(mode_a, 16'h0, "mode");
    wr(key_a, `PMC_KEY_FIRST);
    wr(key_a, `PMC_KEY_SECOND);
    wr(`PMC_CTRL_OFFSET, 16'h0);
    wr(mode_a, 16'h2);
    rdc(mode_a, 16'h0, "mode");
    rdc(key_a, `PMC_KEY_SECOND, "key");
    req_handler <= 1'h1;
    setm(2'h1);
    sl(5'h0E);
    rdc(`PMC_STAT_OFFSET, 16'h0006, "status");
    wk(1'h0, 5'h0E);
    wk(1'h1, 5'h1E);
    req_handler <= 1'h0;
    req_debug <= 1'h1;
    setm(2'h1);
    req_debug <= 1'h0;
    sl(5'h1E);
    rdc(`PMC_STAT_OFFSET, 16'h0008, "status");
    wk(1'h0, 5'h1E);
    rst(1'h0);
    setm(2'h1);
    sl(5'h1E);
    wk(1'h0, 5'h1E);
    rst(1'h1);
    setm(2'h1);
    sl(5'h0E);
    wk(1'h0, 5'h1E);
    finish_test();
  end
endmodule : testbench
